// file: hw/tcc_pkg.sv
// shared constants for the 16-bit capture/compare timer
package tcc_pkg;
   localparam int CNT_W = 16;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   // register addresses
   localparam logic [3:0] A_MODE = 4'h0;
   localparam logic [3:0] A_CRC = 4'h1;
   localparam logic [3:0] A_TOC = 4'h2;
   localparam logic [3:0] A_PRM = 4'h3;
   localparam logic [3:0] A_CYC = 4'h4;
   localparam logic [3:0] A_DUTY = 4'h5;
   localparam logic [3:0] A_CNT = 4'h6;
   localparam logic [3:0] A_STAT = 4'h7;
   localparam logic [3:0] A_IRQ = 4'h8;
   // mode field encodings
   localparam logic [1:0] MD_STOP = 2'h0;
   localparam logic [1:0] MD_EDGE_CLR = 2'h1;
   localparam logic [1:0] MD_FREE = 2'h2;
   localparam logic [1:0] MD_MATCH_CLR = 2'h3;
   // edge select encodings
   localparam logic [1:0] ES_FALL = 2'h0;
   localparam logic [1:0] ES_RISE = 2'h1;
   localparam logic [1:0] ES_BOTH = 2'h3;
   // bit positions
   localparam int B_OVF = 2;
   localparam int B_EXTCLK = 3;
   localparam int B_CRC0 = 0;
   localparam int B_CRC1 = 1;
   localparam int B_CRC2 = 2;
   localparam int B_TOGC = 0;
   localparam int B_TOGD = 1;
   localparam int B_OSE = 2;
   localparam int B_OST = 3;
   localparam int B_TOE = 4;
   localparam int B_LVL = 5;
   // prescaler divide exponents selected by sample_clock_select
   localparam logic [3:0] PS_DIV1 = 4'h0;
   localparam logic [3:0] PS_DIV2 = 4'h2;
   localparam logic [3:0] PS_DIV3 = 4'h4;
   localparam logic [3:0] PS_DIV4 = 4'h6;
   localparam logic [1:0] EVT_ARM = 2'h2;
   localparam logic [15:0] ONES16 = 16'hFFFF;
endpackage

// file: hw/tcc_edge.sv
// two-sample noise filter and edge detector for one trigger pin
`timescale 1ns/100ps
module tcc_edge
   import tcc_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // sampling
   input wire logic sample_in,
   input wire logic level_in,
   input wire logic run_in,
   input wire logic [1:0] edge_sel_in,
   // result
   output logic edge_out
);
   logic s1_q;
   logic s2_q;
   logic ref_q;
   logic stable;
   logic rise;
   logic fall;
   // valid level must be seen on two samples
   assign stable = (s1_q == s2_q);
   // reference resets low, so pin high at the first enable looks like a rise
   assign rise = run_in && stable && s2_q && !ref_q;
   assign fall = run_in && stable && !s2_q && ref_q;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end else if (sample_in) begin
         s1_q <= level_in;
         s2_q <= s1_q;
      end
   end
   // reference holds last level seen while running; stop keeps it so re-enable sees a change
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ref_q <= 1'b0;
      end else if (sample_in && run_in && stable) begin
         ref_q <= s2_q;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         edge_out <= 1'b0;
      end else begin
         edge_out <= sample_in && ((rise && edge_sel_in != ES_FALL) || (fall && edge_sel_in != ES_RISE));
      end
   end
endmodule

// file: hw/tcc_timer.sv
// 16-bit timer with two capture/compare registers, one-shot and pulse output
`timescale 1ns/100ps
module tcc_timer
   import tcc_pkg::*;
#(
   parameter int PS_W = 7
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic nrst_in,
   // register port
   input wire logic [3:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rdata_out,
   // pins
   input wire logic trigger_input_first_in,
   input wire logic shared_port_pin_in,
   output logic timer_output_pin_out,
   output logic timer_output_pin_oe_out,
   // interrupt requests
   output logic cycle_match_irq_out,
   output logic duty_match_irq_out
);
   logic r1_q, rst_n;
   logic t0a_q, t0b_q, t1a_q, t1b_q;
   logic [3:0] mode_q;
   logic [2:0] crc_q;
   logic [5:0] toc_q;
   logic [5:0] prm_q;
   logic [15:0] cycle_capture_compare_q;
   logic [15:0] duty_capture_compare_q;
   logic [15:0] count_register_q;
   logic overflow_flag_q;
   logic ovf_hold_q;
   logic [1:0] irq_flag_q;
   logic [PS_W-1:0] ps_q;
   logic tick_q, fall_q;
   logic out_q, oneshot_q;
   logic [1:0] evt_q;
   logic cap0_q, cap1_q;
   logic run, tick, fall_tick, ext_clk;
   logic e0, e1, cnt_en, wrap, m_cyc, m_duty, clr;
   logic cap_cyc, cap_duty, osp;
   logic [3:0] div;
   logic [1:0] mode;
   // reset release and pin synchronisers
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         r1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         r1_q <= 1'b1;
         rst_n <= r1_q;
      end
   end
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         t0a_q <= 1'b0;
         t0b_q <= 1'b0;
         t1a_q <= 1'b0;
         t1b_q <= 1'b0;
      end else begin
         t0a_q <= trigger_input_first_in;
         t0b_q <= t0a_q;
         t1a_q <= shared_port_pin_in;
         t1b_q <= t1a_q;
      end
   end
   assign mode = mode_q[1:0];
   assign ext_clk = mode_q[B_EXTCLK];
   assign run = (mode != MD_STOP);
   // prescaler: rising half gives count tick, falling half gives capture strobe
   always_comb begin
      unique case (prm_q[1:0])
         2'h0: div = PS_DIV1;
         2'h1: div = PS_DIV2;
         2'h2: div = PS_DIV3;
         2'h3: div = PS_DIV4;
      endcase
   end
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         ps_q <= '0;
         tick_q <= 1'b0;
         fall_q <= 1'b0;
      end else begin
         ps_q <= ps_q + 1'b1;
         tick_q <= (div == PS_DIV1) || ((ps_q & PS_W'((1 << div) - 1)) == '0);
         fall_q <= (div == PS_DIV1) || ((ps_q & PS_W'((1 << div) - 1)) == PS_W'(1 << (div - 1'b1)));
      end
   end
   assign tick = tick_q;
   assign fall_tick = fall_q;
   // first pin filtered with fast clock as count clock, else count clock
   tcc_edge u_e0 (
      .clk_in(mclk_in),
      .rst_n_in(rst_n),
      .sample_in(ext_clk ? 1'b1 : tick),
      .level_in(t0b_q),
      .run_in(run),
      .edge_sel_in(prm_q[5:4]),
      .edge_out(e0)
   );
   tcc_edge u_e1 (
      .clk_in(mclk_in),
      .rst_n_in(rst_n),
      .sample_in(tick),
      .level_in(t1b_q),
      .run_in(run && !toc_q[B_TOE]),
      .edge_sel_in(prm_q[3:2]),
      .edge_out(e1)
   );
   // event counting waits for two edges
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         evt_q <= 2'h0;
      end else if (!run) begin
         evt_q <= 2'h0;
      end else if (ext_clk && e0 && evt_q != EVT_ARM) begin
         evt_q <= evt_q + 2'h1;
      end
   end
   assign cnt_en = run && (ext_clk ? (e0 && evt_q == EVT_ARM) : tick);
   assign osp = wr_in && addr_in == A_TOC && wdata_in[B_OST] && toc_q[B_OSE];
   assign clr = (mode == MD_EDGE_CLR && e0 && !ext_clk) || osp;
   assign wrap = cnt_en && count_register_q == CNT_MAX;
   assign m_cyc = cnt_en && count_register_q == cycle_capture_compare_q;
   assign m_duty = cnt_en && count_register_q == duty_capture_compare_q;
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         count_register_q <= CNT_ZERO;
      end else if (!run || clr) begin
         count_register_q <= CNT_ZERO;
      end else if (cnt_en) begin
         count_register_q <= (mode == MD_MATCH_CLR && m_cyc) ? CNT_ZERO : count_register_q + CNT_ONE;
      end
   end
   // captures latch on the falling half of the count clock
   assign cap_cyc = crc_q[B_CRC0] && !(crc_q[B_CRC1] && prm_q[5:4] == ES_BOTH)
      && (crc_q[B_CRC1] ? e0 : e1);
   assign cap_duty = crc_q[B_CRC2] && e0;
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         cap0_q <= 1'b0;
         cap1_q <= 1'b0;
      end else begin
         cap0_q <= run && (cap_cyc || (cap0_q && !fall_tick));
         cap1_q <= run && (cap_duty || (cap1_q && !fall_tick));
      end
   end
   // capture write wins over software write; stop mid-capture drops the pending capture and keeps the old value
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         cycle_capture_compare_q <= CNT_ZERO;
      end else if (cap0_q && fall_tick) begin
         cycle_capture_compare_q <= count_register_q;
      end else if (wr_in && addr_in == A_CYC) begin
         cycle_capture_compare_q <= wdata_in;
      end
   end
   // no double buffer: a duty rewrite takes effect at once and may re-match
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         duty_capture_compare_q <= CNT_ZERO;
      end else if (cap1_q && fall_tick) begin
         duty_capture_compare_q <= count_register_q;
      end else if (wr_in && addr_in == A_DUTY) begin
         duty_capture_compare_q <= wdata_in;
      end
   end
   // overflow flag: set wins; a clear before the next count is undone
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         overflow_flag_q <= 1'b0;
         ovf_hold_q <= 1'b0;
      end else begin
         if (wrap) begin
            ovf_hold_q <= 1'b1;
         end else if (cnt_en || !run) begin
            ovf_hold_q <= 1'b0;
         end
         if (wrap || ovf_hold_q) begin
            overflow_flag_q <= 1'b1;
         end else if (wr_in && addr_in == A_MODE && !wdata_in[B_OVF]) begin
            overflow_flag_q <= 1'b0;
         end
      end
   end
   // interrupt requests issue on a compare match, or on the rising count tick after a capture or a second-pin edge
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         irq_flag_q <= 2'h0;
         cycle_match_irq_out <= 1'b0;
         duty_match_irq_out <= 1'b0;
      end else begin
         irq_flag_q[0] <= (irq_flag_q[0] && !tick) || (cap0_q && fall_tick)
            || (crc_q[B_CRC1] && e1 && crc_q[B_CRC0]);
         irq_flag_q[1] <= (irq_flag_q[1] && !tick) || (cap1_q && fall_tick);
         cycle_match_irq_out <= (m_cyc && !crc_q[B_CRC0]) || (irq_flag_q[0] && tick);
         duty_match_irq_out <= (m_duty && !crc_q[B_CRC2]) || (irq_flag_q[1] && tick);
      end
   end
   // output: pulse mode sets on cycle match, clears on duty match; one-shot sets at duty, clears at cycle
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         out_q <= 1'b0;
         oneshot_q <= 1'b0;
      end else if (!run) begin
         out_q <= toc_q[B_LVL];
         oneshot_q <= 1'b0;
      end else if (toc_q[B_OSE]) begin
         if (clr) begin
            oneshot_q <= 1'b1;
         end else if (oneshot_q && m_duty) begin
            out_q <= 1'b1;
         end else if (oneshot_q && m_cyc) begin
            out_q <= 1'b0;
            oneshot_q <= 1'b0;
         end
      end else if (m_cyc && toc_q[B_TOGC]) begin
         out_q <= 1'b1;
      end else if (m_duty && toc_q[B_TOGD]) begin
         out_q <= 1'b0;
      end
   end
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         timer_output_pin_out <= 1'b0;
         timer_output_pin_oe_out <= 1'b0;
      end else begin
         timer_output_pin_out <= out_q;
         timer_output_pin_oe_out <= toc_q[B_TOE];
      end
   end
   // control registers
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= 4'h0;
         crc_q <= 3'h0;
         toc_q <= 6'h00;
         prm_q <= 6'h00;
      end else if (wr_in) begin
         if (addr_in == A_MODE) begin
            mode_q <= {wdata_in[B_EXTCLK], 1'b0, wdata_in[1:0]};
         end
         if (addr_in == A_CRC) begin
            crc_q <= wdata_in[2:0];
         end
         if (addr_in == A_TOC) begin
            toc_q <= {wdata_in[5:4], 1'b0, wdata_in[2:0]};
         end
         if (addr_in == A_PRM) begin
            prm_q <= wdata_in[5:0];
         end
      end
   end
   // read data one cycle after the strobe
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         rdata_out <= 16'h0000;
      end else if (rd_in) begin
         unique case (addr_in)
            A_MODE: rdata_out <= {12'h000, mode_q[3], overflow_flag_q, mode_q[1:0]};
            A_CRC: rdata_out <= {13'h0000, crc_q};
            A_TOC: rdata_out <= {10'h000, toc_q & 6'h37};
            A_PRM: rdata_out <= {10'h000, prm_q};
            A_CYC: rdata_out <= cycle_capture_compare_q;
            A_DUTY: rdata_out <= duty_capture_compare_q;
            A_CNT: rdata_out <= count_register_q;
            A_STAT: rdata_out <= {13'h0000, oneshot_q, out_q, run};
            default: rdata_out <= 16'h0000;
         endcase
      end
   end
endmodule

// file: testbench/tcc_timer_sva.sv
// concurrent checks on the timer register port and pins
`timescale 1ns/100ps
module tcc_timer_sva
   import tcc_pkg::*;
#(
   parameter int PS_W = 7
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic nrst_in,
   // register port
   input wire logic [3:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [15:0] rdata_out,
   // pins and requests
   input wire logic trigger_input_first_in,
   input wire logic shared_port_pin_in,
   input wire logic timer_output_pin_out,
   input wire logic timer_output_pin_oe_out,
   input wire logic cycle_match_irq_out,
   input wire logic duty_match_irq_out
);
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!nrst_in);
   property p_unmapped_zero;
      rd_in && addr_in > A_IRQ |=> rdata_out == 16'h0000;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
   property p_soft_trig_zero;
      rd_in && addr_in == A_TOC |=> !rdata_out[B_OST];
   endproperty
   a_soft_trig_zero: assert property (p_soft_trig_zero) else $error("soft trigger read back as one");
   property p_rdata_hold;
      !rd_in |=> $stable(rdata_out);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
   property p_cyc_irq_pulse;
      cycle_match_irq_out |=> !cycle_match_irq_out;
   endproperty
   a_cyc_irq_pulse: assert property (p_cyc_irq_pulse) else $error("cycle request longer than one cycle");
   property p_duty_irq_pulse;
      $rose(duty_match_irq_out) |=> $fell(duty_match_irq_out);
   endproperty
   a_duty_irq_pulse: assert property (p_duty_irq_pulse) else $error("duty request longer than one cycle");
   property p_oe_on;
      wr_in && addr_in == A_TOC && wdata_in[B_TOE] |-> ##[1:3] timer_output_pin_oe_out;
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("output enable did not follow write");
   property p_oe_off;
      wr_in && addr_in == A_TOC && !wdata_in[B_TOE] |-> ##[1:3] !timer_output_pin_oe_out;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("output enable did not drop");
   property p_reset_quiet;
      $rose(nrst_in) |-> rdata_out == 16'h0000 && !timer_output_pin_out && !timer_output_pin_oe_out
         && !cycle_match_irq_out && !duty_match_irq_out;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet at reset release");
   c_cyc_irq: cover property (cycle_match_irq_out);
   c_oe_rise: cover property ($rose(timer_output_pin_oe_out));
   c_out_rise: cover property ($rose(timer_output_pin_out));
endmodule
bind tcc_timer tcc_timer_sva #(.PS_W(PS_W)) tcc_timer_sva_i (.mclk_in(mclk_in), .nrst_in(nrst_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .trigger_input_first_in(trigger_input_first_in), .shared_port_pin_in(shared_port_pin_in),
   .timer_output_pin_out(timer_output_pin_out), .timer_output_pin_oe_out(timer_output_pin_oe_out),
   .cycle_match_irq_out(cycle_match_irq_out), .duty_match_irq_out(duty_match_irq_out));

// file: testbench/tcc_pins_model.sv
// behavioural signal sources for the two trigger pins
`timescale 1ns/100ps
module tcc_pins_model (
   // clock
   input wire logic clk_in,
   // pins
   output logic first_out,
   output logic second_out
);
   initial begin
      first_out = 1'b0;
      second_out = 1'b0;
   end
   // every level lasts four clocks, over two count clocks at divide one
   task automatic level(input logic sel, input logic v);
      @(posedge clk_in);
      if (sel) begin
         second_out <= v;
      end else begin
         first_out <= v;
      end
      repeat (3) @(posedge clk_in);
   endtask
   // a pulse starts only once the previous one is complete
   task automatic pulses(input logic sel, input int n);
      logic v;
      v = sel ? second_out : first_out;
      for (int i = 0; i < n; i++) begin
         level(sel, !v);
         level(sel, v);
      end
   endtask
endmodule

// file: testbench/tcc_timer_bench.sv
// self-checking bench for the capture/compare timer
`timescale 1ns/100ps
module tcc_timer_bench;
   import tcc_pkg::*;
   logic mclk_in;
   logic nrst_in;
   logic [3:0] addr_in;
   logic [15:0] wdata_in;
   logic wr_in;
   logic rd_in;
   logic [15:0] rdata_out;
   logic first_pin;
   logic second_pin;
   logic tout;
   logic toe;
   logic cyc_irq;
   logic duty_irq;
   logic seen;
   int miscompares;
   int tests_run;
   int n;
   int hi;
   int lo;
   logic lv [3] = '{1'b0, 1'b1, 1'b0};
   logic [1:0] edg [3] = '{ES_RISE, ES_RISE, ES_FALL};
   int np [3] = '{5, 3, 3};
   logic [15:0] ex [3] = '{16'h0003, 16'h0002, 16'h0002};
   tcc_timer #(.PS_W(7)) tcc_timer_i (.mclk_in(mclk_in), .nrst_in(nrst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .trigger_input_first_in(first_pin), .shared_port_pin_in(second_pin), .timer_output_pin_out(tout),
      .timer_output_pin_oe_out(toe), .cycle_match_irq_out(cyc_irq), .duty_match_irq_out(duty_irq));
   tcc_pins_model tcc_pins_model_i (.clk_in(mclk_in), .first_out(first_pin), .second_out(second_pin));
   always @(posedge mclk_in) begin
      if (cyc_irq === 1'b1) begin
         seen <= 1'b1;
      end
   end
   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rc(input logic [3:0] a, input logic [15:0] exp, input string what);
      @(posedge mclk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      @(negedge mclk_in);
      check(what, rdata_out, exp);
   endtask
   // bounded wait for the output pin (sel 0) or the cycle request (sel 1) to reach v
   task automatic wait_for(input logic sel, input logic v, input int lim, output int cnt);
      cnt = 0;
      while ((sel ? cyc_irq : tout) !== v && cnt < lim) begin
         @(negedge mclk_in);
         cnt++;
      end
      if ((sel ? cyc_irq : tout) !== v) begin
         miscompares++;
         $display("unexpected wait: expected %h, seen timeout", v);
         report_and_stop();
      end
   endtask
   initial begin
      mclk_in = 1'b0;
      forever #20 mclk_in = ~mclk_in;
   end
   initial begin
      nrst_in = 1'b0;
      addr_in = 4'h0;
      wdata_in = 16'h0000;
      wr_in = 1'b0;
      rd_in = 1'b0;
      seen = 1'b0;
      miscompares = 0;
      tests_run = 0;
      repeat (3) @(posedge mclk_in);
      nrst_in <= 1'b1;
      repeat (3) @(posedge mclk_in);
      rc(A_CNT, CNT_ZERO, "count after reset");
      rc(A_MODE, 16'h0000, "mode after reset");
      wr(4'hF, 16'hFFFF);
      rc(4'hF, 16'h0000, "unmapped read");
      // pulse output: duty 4 above zero and below cycle 9
      wr(A_PRM, 16'h0000);
      wr(A_CYC, 16'h0009);
      wr(A_DUTY, 16'h0004);
      wr(A_TOC, 16'h0013);
      wr(A_MODE, {14'h0000, MD_MATCH_CLR});
      wait_for(1'b0, 1'b1, 200, n);
      wait_for(1'b0, 1'b0, 200, n);
      wait_for(1'b0, 1'b1, 200, n);
      wait_for(1'b0, 1'b0, 200, hi);
      wait_for(1'b0, 1'b1, 200, lo);
      check("pulse high time", 16'(hi), 16'h0005);
      check("pulse period", 16'(hi + lo), 16'h000A);
      // safe cycle then duty change while counting; new cycle stays above the count
      wr(A_TOC, 16'h0012);
      wr(A_CYC, 16'h000B);
      repeat (1) @(posedge mclk_in);
      wr(A_TOC, 16'h0011);
      wr(A_DUTY, 16'h0006);
      repeat (1) @(posedge mclk_in);
      wr(A_TOC, 16'h0013);
      wait_for(1'b0, 1'b1, 200, n);
      wait_for(1'b0, 1'b0, 200, n);
      wait_for(1'b0, 1'b1, 200, n);
      wait_for(1'b0, 1'b0, 200, hi);
      wait_for(1'b0, 1'b1, 200, lo);
      check("new pulse high time", 16'(hi), 16'h0007);
      check("new pulse period", 16'(hi + lo), 16'h000C);
      // one-shot with nonzero compare values, duty below cycle
      wr(A_MODE, 16'h0000);
      wr(A_CYC, 16'h0014);
      wr(A_DUTY, 16'h0008);
      wr(A_TOC, 16'h0017);
      wr(A_MODE, {14'h0000, MD_FREE});
      wr(A_TOC, 16'h001F);
      rc(A_TOC, 16'h0017, "control after soft trigger");
      wait_for(1'b0, 1'b1, 200, n);
      wait_for(1'b0, 1'b0, 200, hi);
      check("one-shot active time", 16'(hi), 16'h000C);
      // source select: second pin only requests, first pin both edges never captures
      wr(A_MODE, 16'h0000);
      wr(A_TOC, 16'h0000);
      wr(A_CYC, 16'h1234);
      wr(A_CRC, 16'h0003);
      wr(A_PRM, 16'h0034);
      wr(A_MODE, {14'h0000, MD_FREE});
      tcc_pins_model_i.pulses(1'b0, 1);
      seen <= 1'b0;
      tcc_pins_model_i.pulses(1'b1, 1);
      // filter and request pipeline lags the pin by several clocks
      repeat (6) @(posedge mclk_in);
      check("request from second pin", {15'h0000, seen}, 16'h0001);
      rc(A_CYC, 16'h1234, "cycle register after edges");
      // shared pin driving as output ignores its input
      wr(A_MODE, 16'h0000);
      wr(A_TOC, 16'h0010);
      wr(A_MODE, {14'h0000, MD_FREE});
      seen <= 1'b0;
      tcc_pins_model_i.pulses(1'b1, 1);
      repeat (6) @(posedge mclk_in);
      check("request while pin drives", {15'h0000, seen}, 16'h0000);
      // pin back to input: a rising edge captures and then requests
      wr(A_MODE, 16'h0000);
      wr(A_TOC, 16'h0000);
      wr(A_CRC, 16'h0001);
      wr(A_MODE, {14'h0000, MD_FREE});
      seen <= 1'b0;
      tcc_pins_model_i.pulses(1'b1, 1);
      repeat (6) @(posedge mclk_in);
      check("request after capture", {15'h0000, seen}, 16'h0001);
      // event counting, with the pin level at enable giving an extra edge
      wr(A_MODE, 16'h0000);
      wr(A_TOC, 16'h0000);
      wr(A_CRC, 16'h0000);
      for (int r = 0; r < 3; r++) begin
         wr(A_MODE, 16'h0000);
         tcc_pins_model_i.level(1'b0, lv[r]);
         wr(A_PRM, {10'h000, edg[r], 4'h0});
         wr(A_MODE, 16'h000A);
         tcc_pins_model_i.pulses(1'b0, np[r]);
         repeat (8) @(posedge mclk_in);
         rc(A_CNT, ex[r], "event count");
      end
      // overflow at the wrap from all ones, long run kept to the end
      wr(A_MODE, 16'h0000);
      wr(A_PRM, 16'h0000);
      wr(A_CYC, CNT_MAX);
      wr(A_MODE, {14'h0000, MD_FREE});
      wait_for(1'b1, 1'b1, 70000, n);
      repeat (4) @(posedge mclk_in);
      rc(A_MODE, 16'h0006, "overflow flag");
      wr(A_MODE, 16'h0002);
      rc(A_MODE, 16'h0002, "overflow cleared");
      // timer stopped before any clock stop
      wr(A_MODE, 16'h0000);
      rc(A_STAT, 16'h0000, "status after stop");
      report_and_stop();
   end
endmodule
